// ---- src/adc_timing_pkg.sv ----
package adc_timing_pkg;

  // ----------------------------------------------------------------
  // divider and sample selects
  // ----------------------------------------------------------------
  localparam logic [1:0] div_sel_4     = 2'h0;
  localparam logic [1:0] div_sel_2     = 2'h1;
  localparam logic [1:0] div_sel_16    = 2'h2;
  localparam logic [1:0] div_sel_8     = 2'h3;
  localparam logic [4:0] div_ratio_4   = 5'h04;
  localparam logic [4:0] div_ratio_2   = 5'h02;
  localparam logic [4:0] div_ratio_16  = 5'h10;
  localparam logic [4:0] div_ratio_8   = 5'h08;
  localparam logic [6:0] sample_len_8  = 7'h08;
  localparam logic [6:0] sample_len_16 = 7'h10;
  localparam logic [6:0] sample_len_32 = 7'h20;
  localparam logic [6:0] sample_len_64 = 7'h40;

  // ----------------------------------------------------------------
  // sequence lengths
  // ----------------------------------------------------------------
  localparam int          bit_steps      = 40;
  localparam logic [1:0]  load_cycles    = 2'h2;
  localparam int          cal_bc_periods = 3328;
  localparam logic [9:0]  code_zero      = 10'h000;
  localparam logic [9:0]  code_full      = 10'h3ff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    st_cal    = 5'b00001,
    st_idle   = 5'b00010,
    st_sample = 5'b00100,
    st_decide = 5'b01000,
    st_load   = 5'b10000
  } phase_e;

  typedef struct packed {
    logic [1:0] basic_clock_divider_select;
    logic [1:0] sample_time_select;
  } converter_control_register_s;

  typedef struct packed {
    phase_e      phase;
    logic [3:0]  div_cnt;
    logic [11:0] step_cnt;
    logic [1:0]  load_cnt;
    logic [1:0]  div_sel;
    logic [1:0]  smp_sel;
    logic [9:0]  held;
    logic [9:0]  sar;
    logic [9:0]  result;
    logic        done;
  } state_s;

endpackage

// ---- src/adc_timing_control.sv ----
`timescale 1ns/10ps
// Behaviour
// - basic clock is cpu clock divided by 4, 2, 16 or 8 per select
// - sample phase lasts 8, 16, 32 or 64 basic-clock periods per select
// - conversion is sample time plus 40 basic periods plus 2 cpu cycles
// - conversion length is a fixed count, never data dependent
// - after reset a calibration of 3328 basic periods runs first
// - input below ground gives 000, above reference gives 3ff
// - input captured only during sample phase, later changes ignored
// - sample and conversion time both set through the two selects
module adc_timing_control #(
  parameter int cal_periods = adc_timing_pkg::cal_bc_periods
) (
  // clock and reset
  input  wire logic                                        clk_sys,
  input  wire logic                                        sys_rst,
  // control
  input  wire adc_timing_pkg::converter_control_register_s ctrl,
  input  wire logic                                        start,
  // analog front end, digitised comparator view
  input  wire logic [9:0]                                  ain_code,
  input  wire logic                                        ain_below_gnd,
  input  wire logic                                        ain_above_ref,
  // status and result
  output logic                                             busy,
  output logic                                             sampling,
  output logic                                             bc_tick,
  output logic [9:0]                                       result,
  output logic                                             result_valid
);

  adc_timing_pkg::state_s s_q;
  adc_timing_pkg::state_s s_d;
  logic [4:0]             ratio;
  logic [6:0]             smp_len;
  logic                   tick;
  logic [9:0]             sat_code;
  logic [9:0]             bit_take;
  logic                   in_idle;
  logic                   in_sample;

  // ----------------------------------------------------------------
  // basic clock divider
  // ----------------------------------------------------------------
  // a 4-bit count is enough because 16 is the slowest ratio
  always_comb
  begin
    case (s_q.div_sel)
      adc_timing_pkg::div_sel_4:
      begin
        ratio = adc_timing_pkg::div_ratio_4;
      end
      adc_timing_pkg::div_sel_2:
      begin
        ratio = adc_timing_pkg::div_ratio_2;
      end
      adc_timing_pkg::div_sel_16:
      begin
        ratio = adc_timing_pkg::div_ratio_16;
      end
      default:
      begin
        ratio = adc_timing_pkg::div_ratio_8;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sample phase length
  // ----------------------------------------------------------------
  always_comb
  begin
    case (s_q.smp_sel)
      2'h0:    smp_len = adc_timing_pkg::sample_len_8;
      2'h1:    smp_len = adc_timing_pkg::sample_len_16;
      2'h2:    smp_len = adc_timing_pkg::sample_len_32;
      default: smp_len = adc_timing_pkg::sample_len_64;
    endcase
  end

  assign tick = (s_q.div_cnt == 4'(ratio - 5'h01));

  // ----------------------------------------------------------------
  // input saturation
  // ----------------------------------------------------------------
  // below ground wins when both flags are set, so a broken front end reads low
  always_comb
  begin
    if (ain_below_gnd)
    begin
      sat_code = adc_timing_pkg::code_zero;
    end
    else if (ain_above_ref)
    begin
      sat_code = adc_timing_pkg::code_full;
    end
    else
    begin
      sat_code = ain_code;
    end
  end

  // ----------------------------------------------------------------
  // bit decisions
  // ----------------------------------------------------------------
  // msb first, one bit on the last tick of every fourth basic period
  for (genvar b = 0; b < 10; b++)
  begin : g_bit
    assign bit_take[b] = tick
                         && (s_q.step_cnt[1:0] == 2'h3)
                         && (s_q.step_cnt[5:2] == 4'(9 - b));
  end

  // ----------------------------------------------------------------
  // phase decode
  // ----------------------------------------------------------------
  assign in_idle   = (s_q.phase == adc_timing_pkg::st_idle);
  assign in_sample = (s_q.phase == adc_timing_pkg::st_sample);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // selects are latched at start so a mid-conversion write cannot stretch it
  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.div_cnt = tick ? 4'h0 : 4'(s_q.div_cnt + 4'h1);
    case (s_q.phase)
      adc_timing_pkg::st_cal:
      begin
        if (tick)
        begin
          s_d.step_cnt = 12'(s_q.step_cnt + 12'h001);
          if (s_q.step_cnt == 12'(cal_periods - 1))
          begin
            s_d.phase = adc_timing_pkg::st_idle;
          end
        end
      end
      adc_timing_pkg::st_idle:
      begin
        s_d.div_sel = ctrl.basic_clock_divider_select;
        s_d.smp_sel = ctrl.sample_time_select;
        if (start)
        begin
          s_d.phase    = adc_timing_pkg::st_sample;
          s_d.div_cnt  = 4'h0;
          s_d.step_cnt = 12'h000;
        end
      end
      adc_timing_pkg::st_sample:
      begin
        // track the input; the last value seen is what gets converted
        s_d.held = sat_code;
        if (tick)
        begin
          s_d.step_cnt = 12'(s_q.step_cnt + 12'h001);
          if (s_q.step_cnt == 12'({5'h00, smp_len} - 12'h001))
          begin
            s_d.phase    = adc_timing_pkg::st_decide;
            s_d.step_cnt = 12'h000;
            s_d.sar      = 10'h000;
          end
        end
      end
      adc_timing_pkg::st_decide:
      begin
        // four basic periods per bit; the count never depends on the code
        if (tick)
        begin
          s_d.step_cnt = 12'(s_q.step_cnt + 12'h001);
          s_d.sar = s_q.sar | (s_q.held & bit_take);
          if (s_q.step_cnt == 12'(adc_timing_pkg::bit_steps - 1))
          begin
            s_d.phase    = adc_timing_pkg::st_load;
            s_d.load_cnt = 2'h0;
          end
        end
      end
      adc_timing_pkg::st_load:
      begin
        s_d.load_cnt = 2'(s_q.load_cnt + 2'h1);
        if (s_q.load_cnt == 2'(adc_timing_pkg::load_cycles - 2'h1))
        begin
          s_d.result = s_q.sar;
          s_d.done   = 1'b1;
          s_d.phase  = adc_timing_pkg::st_idle;
        end
      end
      default:
      begin
        s_d.phase = adc_timing_pkg::st_cal;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    // reset clears the divider select, so calibration always runs at cpu / 4
    if (sys_rst)
    begin
      s_q       <= '0;
      s_q.phase <= adc_timing_pkg::st_cal;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy         = !in_idle;
  assign sampling     = in_sample;
  assign bc_tick      = tick;
  assign result       = s_q.result;
  assign result_valid = s_q.done;

endmodule

// ---- tb/adc_timing_props.sv ----
`timescale 1ns/10ps
module adc_timing_props #(
  parameter int cal_periods = 4
) (
  // clock and reset
  input wire logic                                        clk_sys,
  input wire logic                                        sys_rst,
  // control
  input wire adc_timing_pkg::converter_control_register_s ctrl,
  input wire logic                                        start,
  // status and result
  input wire logic                                        busy,
  input wire logic                                        sampling,
  input wire logic [9:0]                                  result,
  input wire logic                                        result_valid
);
  localparam logic [4:0] nr [4] = '{5'h04, 5'h02, 5'h10, 5'h08};
  localparam logic [6:0] sl [4] = '{7'h08, 7'h10, 7'h20, 7'h40};
  logic [1:0]  dsel_q;
  logic [1:0]  ssel_q;
  logic [11:0] bcnt_q;
  logic [11:0] scnt_q;
  logic        take_w;
  assign take_w = start && !busy;
  // counters restart at each taken start so lengths are per conversion
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dsel_q <= 2'h0;
      ssel_q <= 2'h0;
      bcnt_q <= 12'h000;
      scnt_q <= 12'h000;
    end
    else if (take_w)
    begin
      dsel_q <= ctrl.basic_clock_divider_select;
      ssel_q <= ctrl.sample_time_select;
      bcnt_q <= 12'h000;
      scnt_q <= 12'h000;
    end
    else
    begin
      bcnt_q <= bcnt_q + 12'(busy);
      scnt_q <= scnt_q + 12'(sampling);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    take_w;
  endsequence
  sequence s_conv_end;
    result_valid && $fell(busy);
  endsequence
  AST_TAKE: assert property (s_take |=> busy && sampling)
    else $error("start not taken");
  AST_NO_EARLY: assert property ($rose(sampling) |-> $past(take_w))
    else $error("sample phase without a taken start");
  AST_RV_END: assert property (result_valid |-> s_conv_end)
    else $error("result valid not at busy end");
  AST_RV_PULSE: assert property (result_valid |=> !result_valid)
    else $error("result valid longer than one cycle");
  AST_RES_HOLD: assert property ($changed(result) |-> result_valid)
    else $error("result changed without result valid");
  AST_SMP_LEN: assert property ($fell(sampling) |-> scnt_q == nr[dsel_q] * sl[ssel_q])
    else $error("sample phase length wrong");
  AST_CONV_LEN: assert property (result_valid |-> bcnt_q == nr[dsel_q] * (sl[ssel_q] + 40) + 2)
    else $error("conversion length wrong");
  AST_CAL_LEN: assert property ($fell(busy) && !result_valid |-> bcnt_q == 4 * cal_periods)
    else $error("calibration length wrong");
endmodule
bind adc_timing_control adc_timing_props #(.cal_periods(cal_periods)) i_props (.clk_sys,
  .sys_rst, .ctrl, .start, .busy, .sampling, .result, .result_valid);

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  typedef struct packed {logic [3:0] c; logic [9:0] a; logic lo; logic hi; logic [9:0] r;} row_s;
  localparam logic [11:0] nr [4] = '{12'h004, 12'h002, 12'h010, 12'h008};
  localparam logic [11:0] sl [4] = '{12'h008, 12'h010, 12'h020, 12'h040};
  // codes 10 and 11 keep the basic clock in range at 40 mhz, the rest are timing-only
  row_s rows [5] = '{'{4'h0, 10'h155, 1'b0, 1'b0, 10'h155}, '{4'h5, 10'h2aa, 1'b0, 1'b0, 10'h2aa},
    '{4'ha, 10'h001, 1'b1, 1'b0, 10'h000}, '{4'hf, 10'h200, 1'b0, 1'b1, 10'h3ff},
    '{4'h4, 10'h3fe, 1'b1, 1'b1, 10'h000}};
  logic clk_sys, sys_rst, start, ain_below_gnd, ain_above_ref, busy, sampling, result_valid;
  logic bc_tick, t;
  logic [3:0] ctrl;
  logic [9:0] ain_code, result;
  int errors, checks, n, i;
  adc_timing_control #(.cal_periods(4)) i_dut (.clk_sys, .sys_rst, .ctrl, .start, .ain_code,
    .ain_below_gnd, .ain_above_ref, .busy, .sampling, .bc_tick, .result, .result_valid);
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin errors++; $display("wrong value at %0t: %h %h", $time, got, exp); end
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // counts busy cycles until the given level; a hang counts as a mismatch
  task count_busy(input logic until_rv);
    n = 0;
    for (int k = 0; k < 3000; k++)
    begin
      if (until_rv ? result_valid === 1'b1 : busy === 1'b0) return;
      if (busy === 1'b1) n++;
      if (sampling === 1'b0) ain_code = ~ain_code;
      @(negedge clk_sys);
    end
    errors++;
    summarize();
  endtask
  initial
  begin
    {sys_rst, start, ctrl, ain_code, ain_below_gnd, ain_above_ref} = {2'b10, 16'h0000};
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    count_busy(1'b0);
    chk(n, 12'd16);
    for (i = 0; i < 5; i++)
    begin
      {ctrl, ain_code, ain_below_gnd, ain_above_ref} = rows[i][25:10];
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      count_busy(1'b1);
      chk(result, rows[i].r);
      chk(n, nr[rows[i].c[3:2]] * (sl[rows[i].c[1:0]] + 12'd40) + 12'd2);
      $display("test %0d done", i);
    end
    // start held through a mid-run reset, calibration and a result
    start = 1'b1;
    sys_rst = 1'b1;
    @(negedge clk_sys);
    sys_rst = 1'b0;
    chk(result, 12'h000);
    count_busy(1'b0);
    chk(n, 12'd16);
    @(negedge clk_sys);
    chk({busy, sampling}, 12'h003);
    count_busy(1'b1);
    @(negedge clk_sys);
    chk(busy, 12'h001);
    start = 1'b0;
    t = bc_tick;
    @(negedge clk_sys);
    chk(t ^ bc_tick, 12'h001);
    $display("test reset and back to back done");
    summarize();
  end
endmodule
